/* File: design/fam_align_check.sv */
// Alignment checker for one memory operand.
// Assumes the pipeline presents access attributes in the cycle of the access.
`timescale 1ns/1ps
`default_nettype none
module fam_align_check (
   input wire logic valid_i,
   input wire logic align_mask_en_i,
   input wire logic align_flag_i,
   input wire logic [1:0] priv_level_i,
   input wire fam_pkg::fam_seg_t seg_i,
   input wire logic implicit_sup_i,
   input wire fam_pkg::fam_dtype_t dtype_i,
   input wire logic opsize32_i,
   input wire logic [3:0] addr_lo_i,
   output logic misalign_o,
   output logic gen_prot_o
);
   logic data_seg;
   logic check_on;
   logic [3:0] need_mask;
   logic odd;
   logic ext_bad;
   logic dquad_bad;

   assign data_seg = (seg_i == fam_pkg::SEG_DATA) || (seg_i == fam_pkg::SEG_STACK);
   assign check_on = valid_i && align_mask_en_i && align_flag_i && data_seg &&
                     (priv_level_i == fam_pkg::USER_LEVEL) && !implicit_sup_i;

   always_comb begin
      case (dtype_i)
         fam_pkg::DT_WORD, fam_pkg::DT_SELECTOR, fam_pkg::DT_FAR32: need_mask = fam_pkg::ALN_WORD;
         fam_pkg::DT_DWORD, fam_pkg::DT_SINGLE, fam_pkg::DT_FAR48, fam_pkg::DT_PTR32,
         fam_pkg::DT_TABLE_IMAGE: need_mask = fam_pkg::ALN_DWORD;
         fam_pkg::DT_DOUBLE, fam_pkg::DT_EXTENDED, fam_pkg::DT_QUAD,
         fam_pkg::DT_UNALIGNED_128: need_mask = fam_pkg::ALN_QUAD;
         fam_pkg::DT_ENV_AREA, fam_pkg::DT_SAVE_AREA, fam_pkg::DT_BIT_STRING:
            need_mask = opsize32_i ? fam_pkg::ALN_DWORD : fam_pkg::ALN_WORD;
         default: need_mask = 4'h0;
      endcase
   end

   assign odd = |(addr_lo_i & need_mask);
   // 16-byte classes fault on protection regardless of alignment checking
   assign dquad_bad = valid_i && (dtype_i == fam_pkg::DT_DQUAD) &&
                      |(addr_lo_i & fam_pkg::ALN_DQUAD);
   assign ext_bad = valid_i && (dtype_i == fam_pkg::DT_EXT_AREA) &&
                    |(addr_lo_i & fam_pkg::ALN_DQUAD);

   assign gen_prot_o = dquad_bad || (ext_bad && !(check_on && fam_pkg::EXT_AREA_MISALIGN));
   assign misalign_o = !gen_prot_o && check_on &&
                       (odd || (ext_bad && fam_pkg::EXT_AREA_MISALIGN));
endmodule : fam_align_check
`default_nettype wire

/* File: design/fam_exc_unit.sv */
// Floating-point error, alignment fault and machine-check delivery unit.
// Assumes one instruction slot per cycle from the pipeline and synchronous pins.
//
// How it works
// - Floating-point error vector 16 is raised only with numeric error enable set.
// - SIMD floating-point errors go out on vector 19, never vector 16.
// - Six error types, invalid split in two, each with flag and mask.
// - A masked error yields the default result and raises nothing.
// - An unmasked error sets its flag, pends only with numeric error enable set, and fires at the next waiting instruction.
// - Non-waiting control instructions run without checking the pending error.
// - Extended state save and restore never take the pending error.
// - The floating-point error exception carries no error code.
// - Saved pointer names the waiting instruction; faulting pointer stays in a register.
// - Alignment faults, vector 17, only for data and stack segment accesses.
// - Per data type divisors of 2, 4, 8 or 16 as the table lists.
// - Misaligned 16-byte operands raise protection fault, not alignment fault.
// - Alignment checks need alignment mask, alignment flag and user level 3.
// - Implicit supervisor references never raise an alignment fault.
// - Misaligned extended-state area raises one fixed choice of fault.
// - Unaligned 128-bit moves fault on alignment only when not 8-byte aligned.
// - Alignment fault pushes code zero and points at the unexecuted instruction.
// - Internal or bus machine errors raise the abort on vector 18.
// - An enabled external error pin captures information and raises the abort.
// - With machine-check enable clear, a machine error enters shutdown instead.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module fam_exc_unit (
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Processor state
   input wire logic align_flag_i,
   input wire logic [1:0] priv_level_i,
   // Floating-point execution reports
   input wire logic fpu_err_valid_i,
   input wire logic [6:0] fpu_err_i,
   input wire logic [31:0] fpu_err_ip_i,
   input wire logic fp_insn_valid_i,
   input wire fam_pkg::fam_fp_class_t fp_class_i,
   input wire logic [15:0] insn_cs_i,
   input wire logic [31:0] insn_ip_i,
   input wire logic simd_err_i,
   // Memory operand of the current instruction
   input wire logic mem_valid_i,
   input wire fam_pkg::fam_seg_t mem_seg_i,
   input wire logic mem_implicit_sup_i,
   input wire fam_pkg::fam_dtype_t mem_dtype_i,
   input wire logic mem_opsize32_i,
   input wire logic [31:0] mem_addr_i,
   // Machine error sources
   input wire logic mchk_internal_i,
   input wire logic mchk_bus_i,
   input wire logic [31:0] mchk_bus_addr_i,
   input wire logic machine_error_pin_n_i,
   input wire logic bus_init_error_pin_n_i,
   // Delivery
   output logic cancel_o,
   output logic exc_valid_o,
   output logic [7:0] exc_vector_o,
   output logic exc_abort_o,
   output logic exc_has_code_o,
   output logic [31:0] exc_code_o,
   output logic [15:0] exc_cs_o,
   output logic [31:0] exc_ip_o,
   output logic fpu_default_o,
   output logic shutdown_o
);
   logic [3:0] ctrl_reg;
   logic [5:0] mask_reg;
   logic [6:0] flags_reg;
   logic pend_reg;
   logic [31:0] fpu_ip_reg;
   logic [5:0] mchk_stat_reg;
   logic [31:0] mchk_addr_reg;
   logic pin_prev_reg;
   logic exc_valid_reg;
   logic [7:0] exc_vector_reg;
   logic exc_abort_reg;
   logic exc_has_code_reg;
   logic [31:0] exc_code_reg;
   logic [15:0] exc_cs_reg;
   logic [31:0] exc_ip_reg;
   logic fpu_default_reg;
   logic [31:0] rdata_reg;
   logic [7:0] last_vec_reg;

   logic [3:0] ctrl_next;
   logic [5:0] mask_next;
   logic [6:0] flags_next;
   logic pend_next;
   logic [5:0] mchk_stat_next;

   // Decode
   wire num_err_en = ctrl_reg[fam_pkg::CTRL_NUM_ERR_BIT];
   wire align_mask_en = ctrl_reg[fam_pkg::CTRL_ALIGN_MASK_BIT];
   wire mchk_en = ctrl_reg[fam_pkg::CTRL_MCHK_EN_BIT];
   wire pin_en = ctrl_reg[fam_pkg::CTRL_PIN_EN_BIT];
   wire shut = mchk_stat_reg[fam_pkg::MCHK_SHUTDOWN];
   wire wr_ctrl = reg_wr_i && (reg_addr_i == fam_pkg::OFS_CTRL);
   wire wr_mask = reg_wr_i && (reg_addr_i == fam_pkg::OFS_FPU_MASK);
   wire wr_fstat = reg_wr_i && (reg_addr_i == fam_pkg::OFS_FPU_STATUS);
   wire wr_mstat = reg_wr_i && (reg_addr_i == fam_pkg::OFS_MCHK_STATUS);

   // Floating-point error tracking
   wire [6:0] err_in = fpu_err_valid_i ? fpu_err_i : 7'h00;
   wire [6:0] full_mask = {mask_reg[fam_pkg::FLG_INVALID], mask_reg};
   wire unmasked_err = |(err_in & ~full_mask);
   wire masked_only = |err_in && !unmasked_err;
   wire is_waiting = fp_insn_valid_i &&
                     ((fp_class_i == fam_pkg::FC_WAITING) || (fp_class_i == fam_pkg::FC_WAIT));
   wire insn_clear = fp_insn_valid_i &&
                     ((fp_class_i == fam_pkg::FC_INIT_NW) || (fp_class_i == fam_pkg::FC_CLEAR_NW));
   wire fpu_want = is_waiting && pend_reg && num_err_en;

   // Alignment check of the memory operand
   wire misalign;
   wire gen_prot;
   fam_align_check u_align (
      .valid_i(mem_valid_i),
      .align_mask_en_i(align_mask_en),
      .align_flag_i(align_flag_i),
      .priv_level_i(priv_level_i),
      .seg_i(mem_seg_i),
      .implicit_sup_i(mem_implicit_sup_i),
      .dtype_i(mem_dtype_i),
      .opsize32_i(mem_opsize32_i),
      .addr_lo_i(mem_addr_i[3:0]),
      .misalign_o(misalign),
      .gen_prot_o(gen_prot)
   );

   // Machine error sources; a held pin counts once on assertion
   wire pin_level = pin_en && (!machine_error_pin_n_i || !bus_init_error_pin_n_i);
   wire pin_event = pin_level && !pin_prev_reg;
   wire mchk_event = !shut && (mchk_internal_i || mchk_bus_i || pin_event);

   // Single winner per cycle: abort, protection, alignment, pending, SIMD
   wire take_mchk = mchk_event && mchk_en;
   wire go_shut = mchk_event && !mchk_en;
   wire open_slot = !mchk_event && !shut;
   wire take_gen_prot = open_slot && gen_prot;
   wire take_misalign = open_slot && !gen_prot && misalign;
   wire mem_fault = gen_prot || misalign;
   wire take_fpu = open_slot && !mem_fault && fpu_want;
   wire take_simd = open_slot && !mem_fault && !fpu_want && simd_err_i;
   wire take_any = take_mchk || take_gen_prot || take_misalign || take_fpu || take_simd;

   wire [7:0] vec_sel = take_mchk ? fam_pkg::VEC_MCHK :
                        take_gen_prot ? fam_pkg::VEC_GEN_PROT :
                        take_misalign ? fam_pkg::VEC_MISALIGN :
                        take_fpu ? fam_pkg::VEC_FPU : fam_pkg::VEC_SIMD;
   wire code_sel = take_gen_prot || take_misalign;
   wire [31:0] code_val = take_misalign ? fam_pkg::MISALIGN_ERR_CODE : fam_pkg::GEN_PROT_ERR_CODE;

   // Cancelling the instruction keeps architectural state unchanged
   assign cancel_o = take_any || go_shut;

   // Next-state logic; hardware sets win over any clear in the same cycle
   wire [6:0] sw_flag_clr = wr_fstat ? reg_wdata_i[6:0] : 7'h00;
   wire sw_pend_clr = wr_fstat && reg_wdata_i[fam_pkg::FPU_PEND_BIT];
   wire [6:0] flag_clr = sw_flag_clr | {7{insn_clear}};
   wire pend_set = unmasked_err && num_err_en;
   wire pend_clr = take_fpu || insn_clear || sw_pend_clr;

   always_comb begin
      ctrl_next = wr_ctrl ? reg_wdata_i[3:0] : ctrl_reg;
      mask_next = wr_mask ? reg_wdata_i[5:0] : mask_reg;
      flags_next = (flags_reg & ~flag_clr) | err_in;
      pend_next = pend_set || (pend_reg && !pend_clr);
      mchk_stat_next = mchk_stat_reg;
      if (wr_mstat) begin
         mchk_stat_next[4:0] = mchk_stat_reg[4:0] & ~reg_wdata_i[4:0];
      end
      if (mchk_event) begin
         mchk_stat_next[fam_pkg::MCHK_VALID] = 1'b1;
         mchk_stat_next[fam_pkg::MCHK_INTERNAL] = mchk_stat_next[fam_pkg::MCHK_INTERNAL] | mchk_internal_i;
         mchk_stat_next[fam_pkg::MCHK_BUS] = mchk_stat_next[fam_pkg::MCHK_BUS] | mchk_bus_i;
         mchk_stat_next[fam_pkg::MCHK_PIN_ERR] = mchk_stat_next[fam_pkg::MCHK_PIN_ERR] |
                                                 (pin_event && !machine_error_pin_n_i);
         mchk_stat_next[fam_pkg::MCHK_PIN_INIT] = mchk_stat_next[fam_pkg::MCHK_PIN_INIT] |
                                                  (pin_event && !bus_init_error_pin_n_i);
      end
      if (go_shut) begin
         mchk_stat_next[fam_pkg::MCHK_SHUTDOWN] = 1'b1;
      end
   end

   // Register read mux, unmapped addresses read zero
   wire [31:0] rd_mux =
      (reg_addr_i == fam_pkg::OFS_CTRL) ? {28'h0000000, ctrl_reg} :
      (reg_addr_i == fam_pkg::OFS_FPU_MASK) ? {26'h0, mask_reg} :
      (reg_addr_i == fam_pkg::OFS_FPU_STATUS) ? {24'h000000, pend_reg, flags_reg} :
      (reg_addr_i == fam_pkg::OFS_FPU_IP) ? fpu_ip_reg :
      (reg_addr_i == fam_pkg::OFS_MCHK_STATUS) ? {26'h0, mchk_stat_reg} :
      (reg_addr_i == fam_pkg::OFS_MCHK_ADDR) ? mchk_addr_reg :
      (reg_addr_i == fam_pkg::OFS_LAST_EXC) ? {24'h000000, last_vec_reg} : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ctrl_reg <= fam_pkg::CTRL_RST;
         mask_reg <= fam_pkg::MASK_RST;
         flags_reg <= fam_pkg::FLG_RST;
         pend_reg <= 1'b0;
         mchk_stat_reg <= 6'h00;
         pin_prev_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
         flags_reg <= flags_next;
         pend_reg <= pend_next;
         mchk_stat_reg <= mchk_stat_next;
         pin_prev_reg <= pin_level;
         rdata_reg <= reg_rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   // Captured pointers and addresses
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         fpu_ip_reg <= 32'h0000_0000;
         mchk_addr_reg <= 32'h0000_0000;
         last_vec_reg <= 8'h00;
      end else begin
         if (fpu_err_valid_i && |fpu_err_i) begin
            fpu_ip_reg <= fpu_err_ip_i;
         end
         if (mchk_event) begin
            mchk_addr_reg <= mchk_bus_addr_i;
         end
         if (take_any) begin
            last_vec_reg <= vec_sel;
         end
      end
   end

   // Delivery record, one cycle after the decision
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         exc_valid_reg <= 1'b0;
         exc_vector_reg <= 8'h00;
         exc_abort_reg <= 1'b0;
         exc_has_code_reg <= 1'b0;
         exc_code_reg <= 32'h0000_0000;
         exc_cs_reg <= 16'h0000;
         exc_ip_reg <= 32'h0000_0000;
         fpu_default_reg <= 1'b0;
      end else begin
         exc_valid_reg <= take_any;
         exc_vector_reg <= take_any ? vec_sel : 8'h00;
         exc_abort_reg <= take_mchk;
         exc_has_code_reg <= take_any && code_sel;
         exc_code_reg <= (take_any && code_sel) ? code_val : 32'h0000_0000;
         exc_cs_reg <= take_any ? insn_cs_i : 16'h0000;
         exc_ip_reg <= take_any ? insn_ip_i : 32'h0000_0000;
         fpu_default_reg <= masked_only;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign exc_valid_o = exc_valid_reg;
   assign exc_vector_o = exc_vector_reg;
   assign exc_abort_o = exc_abort_reg;
   assign exc_has_code_o = exc_has_code_reg;
   assign exc_code_o = exc_code_reg;
   assign exc_cs_o = exc_cs_reg;
   assign exc_ip_o = exc_ip_reg;
   assign fpu_default_o = fpu_default_reg;
   assign shutdown_o = shut;

   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   fpu_deliver_a: assert property (take_fpu |=> exc_valid_o && exc_vector_o == fam_pkg::VEC_FPU &&
                                   exc_ip_o == $past(insn_ip_i) && !exc_has_code_o)
      else $error("pending fpu error not delivered at waiting instruction");
   fpu_enable_a: assert property (exc_valid_o && exc_vector_o == fam_pkg::VEC_FPU |->
                                  $past(num_err_en) && $past(is_waiting))
      else $error("fpu error vector without enable or waiting instruction");
   nowait_skip_a: assert property (fp_insn_valid_i && !is_waiting && !mchk_event && !mem_fault &&
                                   !simd_err_i && !shut |=> !exc_valid_o)
      else $error("non-waiting instruction took an exception");
   ext_state_a: assert property (fp_insn_valid_i && (fp_class_i == fam_pkg::FC_EXT_SAVE ||
                                 fp_class_i == fam_pkg::FC_EXT_RESTORE) && pend_reg && !wr_fstat |=> pend_reg &&
                                 exc_vector_o != fam_pkg::VEC_FPU)
      else $error("extended state instruction consumed pending error");
   masked_default_a: assert property (masked_only && !pend_reg |=> fpu_default_o && !pend_reg)
      else $error("masked error did not give default result");
   pend_hold_a: assert property (pend_reg && !take_fpu && !insn_clear && !wr_fstat |=> pend_reg)
      else $error("pending error dropped without delivery or clear");
   misalign_code_a: assert property (take_misalign |=> exc_vector_o == fam_pkg::VEC_MISALIGN &&
                                     exc_has_code_o && exc_code_o == 32'h0000_0000 && $past(cancel_o))
      else $error("alignment fault without zero error code");
   misalign_en_a: assert property (misalign |-> align_mask_en && align_flag_i &&
                                   priv_level_i == fam_pkg::USER_LEVEL && !mem_implicit_sup_i)
      else $error("alignment fault outside enabled user mode");
   code_seg_a: assert property (mem_seg_i == fam_pkg::SEG_CODE || mem_seg_i == fam_pkg::SEG_SYSTEM |->
                                !misalign)
      else $error("alignment fault on code or system segment");
   dquad_prot_a: assert property (take_gen_prot |=> exc_valid_o && exc_vector_o == fam_pkg::VEC_GEN_PROT &&
                                  exc_has_code_o)
      else $error("misaligned 16-byte operand not a protection fault");
   simd_vec_a: assert property (take_simd |=> exc_vector_o == fam_pkg::VEC_SIMD)
      else $error("SIMD error not on its own vector");
   mchk_abort_a: assert property (take_mchk |=> exc_valid_o && exc_abort_o &&
                                  exc_vector_o == fam_pkg::VEC_MCHK && mchk_stat_reg[fam_pkg::MCHK_VALID])
      else $error("machine error not delivered as abort");
   mchk_shut_a: assert property (go_shut |=> shutdown_o && !exc_valid_o ##1 shutdown_o)
      else $error("machine error with check disabled did not shut down");

   fpu_path_c: cover property (pend_set ##[1:20] take_fpu);
   misalign_path_c: cover property (take_misalign);
   pin_abort_c: cover property (pin_event && mchk_en);
   shutdown_c: cover property (go_shut);
endmodule : fam_exc_unit
`default_nettype wire

/* File: shared/fam_pkg.sv */
// Constants, register map and encodings of the fault delivery unit.
// Assumes a single core clock domain and a plain register port.
`default_nettype none
package fam_pkg;
   // Register byte offsets on the plain register port
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FPU_MASK = 8'h04;
   localparam logic [7:0] OFS_FPU_STATUS = 8'h08;
   localparam logic [7:0] OFS_FPU_IP = 8'h0c;
   localparam logic [7:0] OFS_MCHK_STATUS = 8'h10;
   localparam logic [7:0] OFS_MCHK_ADDR = 8'h14;
   localparam logic [7:0] OFS_LAST_EXC = 8'h18;
   // Control register fields
   localparam int CTRL_W = 4;
   localparam int CTRL_NUM_ERR_BIT = 0;
   localparam int CTRL_ALIGN_MASK_BIT = 1;
   localparam int CTRL_MCHK_EN_BIT = 2;
   localparam int CTRL_PIN_EN_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   // Floating-point status flags; stack fault shares the invalid mask
   localparam int FLG_W = 7;
   localparam int FLG_INVALID = 0;
   localparam int FLG_DENORM = 1;
   localparam int FLG_ZERO_DIV = 2;
   localparam int FLG_OVERFLOW = 3;
   localparam int FLG_UNDERFLOW = 4;
   localparam int FLG_INEXACT = 5;
   localparam int FLG_STACK = 6;
   localparam int FPU_PEND_BIT = 7;
   localparam int MASK_W = 6;
   localparam logic [5:0] MASK_RST = 6'h3f;
   localparam logic [6:0] FLG_RST = 7'h00;
   // Machine-check status fields
   localparam int MCHK_W = 6;
   localparam int MCHK_VALID = 0;
   localparam int MCHK_INTERNAL = 1;
   localparam int MCHK_BUS = 2;
   localparam int MCHK_PIN_ERR = 3;
   localparam int MCHK_PIN_INIT = 4;
   localparam int MCHK_SHUTDOWN = 5;
   // Exception vectors
   localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
   localparam logic [7:0] VEC_FPU = 8'h10;
   localparam logic [7:0] VEC_MISALIGN = 8'h11;
   localparam logic [7:0] VEC_MCHK = 8'h12;
   localparam logic [7:0] VEC_SIMD = 8'h13;
   localparam logic [31:0] MISALIGN_ERR_CODE = 32'h0000_0000;
   localparam logic [31:0] GEN_PROT_ERR_CODE = 32'h0000_0000;
   localparam logic [1:0] USER_LEVEL = 2'h3;
   // Low-address masks of the alignment classes
   localparam logic [3:0] ALN_WORD = 4'h1;
   localparam logic [3:0] ALN_DWORD = 4'h3;
   localparam logic [3:0] ALN_QUAD = 4'h7;
   localparam logic [3:0] ALN_DQUAD = 4'hf;
   // Misaligned extended-state area: 1 raises misalign fault when alignment checking is on (else protection fault), 0 protection fault
   localparam logic EXT_AREA_MISALIGN = 1'b0;

   typedef enum logic [3:0] {
      FC_NONE, FC_WAITING, FC_WAIT, FC_INIT_NW, FC_CLEAR_NW, FC_STSW_NW,
      FC_STCW_NW, FC_STENV_NW, FC_SAVE_NW, FC_EXT_SAVE, FC_EXT_RESTORE
   } fam_fp_class_t;

   typedef enum logic [4:0] {
      DT_BYTE, DT_WORD, DT_DWORD, DT_SINGLE, DT_DOUBLE, DT_EXTENDED, DT_QUAD,
      DT_DQUAD, DT_SELECTOR, DT_FAR32, DT_FAR48, DT_PTR32, DT_TABLE_IMAGE,
      DT_ENV_AREA, DT_SAVE_AREA, DT_BIT_STRING, DT_EXT_AREA, DT_UNALIGNED_128
   } fam_dtype_t;

   typedef enum logic [1:0] {SEG_DATA, SEG_STACK, SEG_CODE, SEG_SYSTEM} fam_seg_t;
endpackage : fam_pkg
`default_nettype wire

/* File: testbench/fam_err_agent.sv */
// External bus agent: drives the two active-low error pins.
// Assumes pull-ups on both pins, so a released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module fam_err_agent (
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic sel_i,
   output logic err_pin_n_o,
   output logic init_pin_n_o
);
   logic [1:0] cnt_reg = 2'h0;
   logic sel_reg = 1'b0;
   always @(posedge clk_i) begin
      if (fire_i) begin
         cnt_reg <= 2'h3;
         sel_reg <= sel_i;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end
   // Low for a few cycles, then back to the pull-up level
   assign err_pin_n_o = !(cnt_reg != 2'h0 && !sel_reg);
   assign init_pin_n_o = !(cnt_reg != 2'h0 && sel_reg);
endmodule : fam_err_agent
`default_nettype wire

/* File: testbench/tb_fam_exc_unit.sv */
// Self-checking bench of the fault delivery unit.
// Assumes the error-pin agent model and a 20 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module tb_fam_exc_unit;
   logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, align_flag_i = 1'b1, fire = 1'b0;
   logic fpu_err_valid_i = 1'b0, fp_insn_valid_i = 1'b0, simd_err_i = 1'b0, mem_valid_i = 1'b0, sel = 1'b0;
   logic mem_implicit_sup_i = 1'b0, mchk_internal_i = 1'b0, op32 = 1'b1, cx = 1'b0;
   logic [1:0] priv_level_i = 2'h3;
   logic [3:0] la;
   logic [6:0] fpu_err_i = 7'h00;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, mem_addr_i = 32'h0, insn_ip_i = 32'h0, ip = 32'h100;
   fam_pkg::fam_fp_class_t fp_class_i = fam_pkg::FC_NONE;
   fam_pkg::fam_seg_t mem_seg_i = fam_pkg::SEG_DATA;
   fam_pkg::fam_dtype_t mem_dtype_i = fam_pkg::DT_BYTE;
   fam_pkg::fam_dtype_t dt[6] = '{fam_pkg::DT_WORD, fam_pkg::DT_DWORD, fam_pkg::DT_DOUBLE,
      fam_pkg::DT_UNALIGNED_128, fam_pkg::DT_DQUAD, fam_pkg::DT_EXT_AREA};
   logic [3:0] mk[6] = '{4'h1, 4'h3, 4'h7, 4'h7, 4'hf, 4'hf};
   logic [7:0] vc[6] = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h0d, 8'h0d};
   wire logic err_n, init_n, exc_valid_o, exc_abort_o, exc_has_code_o, fpu_default_o, shutdown_o, cancel;
   wire logic [7:0] exc_vector_o;
   wire logic [15:0] cs;
   wire logic [31:0] reg_rdata_o, exc_ip_o, exc_code_o;
   logic [39:0] q[$];
   int err_total = 0, checks = 0;
   fam_exc_unit i_fam_exc_unit (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .align_flag_i(align_flag_i), .priv_level_i(priv_level_i), .fpu_err_valid_i(fpu_err_valid_i),
      .fpu_err_i(fpu_err_i), .fpu_err_ip_i(32'habc), .fp_insn_valid_i(fp_insn_valid_i), .fp_class_i(fp_class_i),
      .insn_cs_i(16'h8), .insn_ip_i(insn_ip_i), .simd_err_i(simd_err_i), .mem_valid_i(mem_valid_i),
      .mem_seg_i(mem_seg_i), .mem_implicit_sup_i(mem_implicit_sup_i), .mem_dtype_i(mem_dtype_i),
      .mem_opsize32_i(op32), .mem_addr_i(mem_addr_i), .mchk_internal_i(mchk_internal_i), .mchk_bus_i(1'b0),
      .mchk_bus_addr_i(32'h0), .machine_error_pin_n_i(err_n), .bus_init_error_pin_n_i(init_n), .cancel_o(cancel),
      .exc_valid_o(exc_valid_o), .exc_vector_o(exc_vector_o), .exc_abort_o(exc_abort_o),
      .exc_has_code_o(exc_has_code_o), .exc_code_o(exc_code_o), .exc_cs_o(cs), .exc_ip_o(exc_ip_o),
      .fpu_default_o(fpu_default_o), .shutdown_o(shutdown_o));
   fam_err_agent i_fam_err_agent (.clk_i(clk_i), .fire_i(fire), .sel_i(sel), .err_pin_n_o(err_n),
      .init_pin_n_o(init_n));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
      if (!wr) chk(reg_rdata_o, d);
   endtask : rw
   // Byte type stands for no memory operand
   task automatic slot(input fam_pkg::fam_fp_class_t c, input fam_pkg::fam_dtype_t d, input logic [3:0] a,
                       input logic [7:0] v);
      ip = ip + 32'h4;
      fp_insn_valid_i <= c != fam_pkg::FC_NONE;
      fp_class_i <= c;
      mem_valid_i <= d != fam_pkg::DT_BYTE;
      mem_dtype_i <= d;
      mem_addr_i <= {28'h0, a};
      insn_ip_i <= ip;
      if (v != 8'h00) q.push_back({v, ip});
      @(posedge clk_i);
      fp_insn_valid_i <= 1'b0;
      mem_valid_i <= 1'b0;
      simd_err_i <= 1'b0;
      mchk_internal_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : slot
   task automatic ferr(input logic [6:0] e, input logic dflt);
      fpu_err_valid_i <= 1'b1;
      fpu_err_i <= e;
      @(posedge clk_i);
      fpu_err_valid_i <= 1'b0;
      @(posedge clk_i);
      chk(fpu_default_o, dflt);
   endtask : ferr
   task automatic pin(input logic s);
      sel <= s;
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : pin
   always @(posedge clk_i) begin
      cx <= cancel;
      if (exc_valid_o === 1'b1 && q.size() == 0) chk(exc_vector_o, 8'h00);
      else if (exc_valid_o === 1'b1) begin
         chk(exc_vector_o, q[0][39:32]);
         chk(exc_ip_o, q[0][31:0]);
         chk(exc_has_code_o, q[0][39:32] inside {8'h0d, 8'h11});
         chk(exc_abort_o, q[0][39:32] == 8'h12);
         chk(exc_code_o, 32'h0);
         chk(cs, 32'h8);
         chk(cx, 1'b1);
         q.delete(0);
      end
   end
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      err_total++;
      summarize();
   end
   initial begin
      void'($urandom(32'h107c));
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rw(0, fam_pkg::OFS_FPU_MASK, 32'h3f);
      rw(0, 8'h1c, 32'h0);
      rw(1, fam_pkg::OFS_CTRL, 32'hf);
      rw(1, fam_pkg::OFS_FPU_MASK, 32'h0);
      ferr(7'h04, 1'b0);
      for (int k = 5; k <= 10; k++) slot(fam_pkg::fam_fp_class_t'(k), fam_pkg::DT_BYTE, 4'h0, 8'h00);
      rw(0, fam_pkg::OFS_FPU_STATUS, 32'h84);
      slot(fam_pkg::FC_WAIT, fam_pkg::DT_BYTE, 4'h0, 8'h10);
      rw(0, fam_pkg::OFS_FPU_IP, 32'habc);
      ferr(7'h01, 1'b0);
      slot(fam_pkg::FC_CLEAR_NW, fam_pkg::DT_BYTE, 4'h0, 8'h00);
      slot(fam_pkg::FC_WAITING, fam_pkg::DT_BYTE, 4'h0, 8'h00);
      rw(1, fam_pkg::OFS_CTRL, 32'he);
      ferr(7'h08, 1'b0);
      rw(1, fam_pkg::OFS_CTRL, 32'hf);
      slot(fam_pkg::FC_WAITING, fam_pkg::DT_BYTE, 4'h0, 8'h00);
      rw(1, fam_pkg::OFS_FPU_MASK, 32'h3f);
      ferr(7'h20, 1'b1);
      slot(fam_pkg::FC_WAITING, fam_pkg::DT_BYTE, 4'h0, 8'h00);
      simd_err_i <= 1'b1;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_BYTE, 4'h0, 8'h13);
      $display("test fpu finished");
      for (int k = 0; k < 18; k++) begin
         la = 4'($urandom());
         slot(fam_pkg::FC_NONE, dt[k % 6], la, (la & mk[k % 6]) != 4'h0 ? vc[k % 6] : 8'h00);
      end
      slot(fam_pkg::FC_NONE, fam_pkg::DT_EXT_AREA, 4'h8, 8'h0d);
      priv_level_i <= 2'h0;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_WORD, 4'h1, 8'h00);
      priv_level_i <= 2'h3;
      mem_seg_i <= fam_pkg::SEG_CODE;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_WORD, 4'h1, 8'h00);
      mem_seg_i <= fam_pkg::SEG_STACK;
      mem_implicit_sup_i <= 1'b1;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_DWORD, 4'h2, 8'h00);
      mem_implicit_sup_i <= 1'b0;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_DWORD, 4'h2, 8'h11);
      op32 <= 1'b0;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_BIT_STRING, 4'h2, 8'h00);
      op32 <= 1'b1;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_ENV_AREA, 4'h2, 8'h11);
      $display("test align finished");
      mchk_internal_i <= 1'b1;
      slot(fam_pkg::FC_NONE, fam_pkg::DT_BYTE, 4'h0, 8'h12);
      q.push_back({8'h12, ip});
      pin(1'b0);
      rw(0, fam_pkg::OFS_MCHK_STATUS, 32'h0b);
      rw(1, fam_pkg::OFS_CTRL, 32'hb);
      pin(1'b1);
      chk(shutdown_o, 1'b1);
      chk(q.size(), 32'h0);
      $display("test machine finished");
      summarize();
   end
endmodule : tb_fam_exc_unit
`default_nettype wire
